// [sim/adcot_link_rx.sv]
/*
 Link receiver model: takes octets and pairs the high and low octet of a word.
 Assumes octets are offered with valid and ready on the encode clock.
*/
module adcot_link_rx
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] octet_i,
    input wire logic octet_valid_i,
    output logic octet_ready_o,
    input wire logic hold_i,
    input wire logic slow_i,
    output logic [15:0] word_o,
    output logic word_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_r;
    logic lo_r;
    // A slow receiver takes one octet in four, so the sender has to wait on it.
    assign octet_ready_o = !hold_i && (!slow_i || cnt_r == 2'h0);
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_r <= 2'h0;
            lo_r <= 1'b0;
            word_o <= 16'h0000;
            word_valid_o <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 2'h1;
            word_valid_o <= octet_valid_i && octet_ready_o && lo_r;
            if (octet_valid_i && octet_ready_o)
            begin
                lo_r <= !lo_r;
                word_o <= lo_r ? {word_o[15:8], octet_i} : {octet_i, 8'h00};
            end
        end
    end
endmodule

// [sim/adcot_top_chk.sv]
/*
 Port checker for the output test block, bound into its top module.
 Assumes one encode clock domain and the asynchronous active-low reset.
*/
module adcot_top_chk
    import adcot_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic sample_valid_i,
    input wire logic sample_ready_o,
    input wire logic [7:0] octet_o,
    input wire logic octet_valid_o,
    input wire logic octet_ready_i,
    input wire logic spi_csb_n_i,
    input wire logic spi_sdio_oe_o,
    input wire logic pll_high_rate_o,
    input wire logic [7:0] driver_swing_o,
    input wire logic bist_busy_o
);
    logic lo_r;
    logic [9:0] cnt_r;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            lo_r <= 1'b0;
            cnt_r <= 10'h000;
        end
        else
        begin
            lo_r <= lo_r ^ (octet_valid_o && octet_ready_i);
            cnt_r <= !bist_busy_o ? 10'h000 : cnt_r + 10'(sample_valid_i && sample_ready_o);
        end
    end
    AST_OCT_HOLD: assert property (octet_valid_o && !octet_ready_i |=> octet_valid_o && $stable(octet_o))
        else $error("Octet changed before it was taken.");
    AST_TAIL: assert property (octet_valid_o && lo_r |-> octet_o[1:0] == 2'h0)
        else $error("Tail bits of the low octet are not zero.");
    AST_LO_NEXT: assert property (octet_valid_o && octet_ready_i && !lo_r |=> octet_valid_o)
        else $error("Low octet did not follow the high octet.");
    AST_OE_IDLE: assert property (spi_csb_n_i [*3] |-> !spi_sdio_oe_o)
        else $error("Data pin driven while chip select is high.");
    AST_CFG_STABLE: assert property (spi_csb_n_i [*3] |-> $stable(pll_high_rate_o) && $stable(driver_swing_o))
        else $error("Configuration output changed outside a register frame.");
    AST_BIST_MAX: assert property (cnt_r <= 10'h200)
        else $error("Self-test ran past 512 samples.");
    AST_BIST_END: assert property ($fell(bist_busy_o) |-> cnt_r == 10'h200)
        else $error("Self-test stopped after a count other than 512.");
    AST_BIST_ROSE: assert property ($rose(bist_busy_o) |-> $past(spi_csb_n_i) == 1'b0)
        else $error("Self-test started without a register write.");
endmodule
bind adcot_top adcot_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .octet_o(octet_o),
    .octet_valid_o(octet_valid_o), .octet_ready_i(octet_ready_i), .spi_csb_n_i(spi_csb_n_i),
    .spi_sdio_oe_o(spi_sdio_oe_o), .pll_high_rate_o(pll_high_rate_o),
    .driver_swing_o(driver_swing_o), .bist_busy_o(bist_busy_o));

// [sim/adcot_top_tb.sv]
/*
 Testbench for the output test block: serial register tasks, sample feed and
 word checks through the link receiver model.
 Assumes the encode clock alone; the serial clock is slowed to eight clocks a bit.
*/
module adcot_top_tb
    import adcot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n = 1'b0, valid = 1'b0, sclk = 1'b0, csb = 1'b1, drv = 1'b0;
    logic hold = 1'b0, slow = 1'b0, rdy, ov, ordy, so, soe, pll, busy, wv, sdio;
    logic [13:0] smp = 14'h0000;
    logic [7:0] oct, swing, dq;
    logic [15:0] word;
    logic [15:0] got[$];
    int n_errors = 0;
    int n_compared = 0;
    logic [13:0] ss[4] = '{14'h1fff, 14'h2000, 14'h3fff, 14'h0123};
    logic [7:0] pc[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h26, 8'h15, 8'h08};
    logic [13:0] pa[8] = '{14'h0000, 14'h1fff, 14'h2000, 14'h2aaa, 14'h3fff, 14'h0092,
        14'h3aff, 14'h04bf};
    logic [13:0] pb[8] = '{14'h0000, 14'h1fff, 14'h2000, 14'h1555, 14'h0000, 14'h0092,
        14'h3aff, 14'h0a80};
    // The pin level is resolved here, so the device's read data wins while it drives.
    assign sdio = soe ? so : drv;
    initial
        forever #20 clk = ~clk;
    adcot_top #(.FIFO_DEPTH(8)) dut (.clk_i(clk), .arst_n_i(arst_n), .sample_bits_i(smp),
        .sample_valid_i(valid), .sample_ready_o(rdy), .octet_o(oct), .octet_valid_o(ov),
        .octet_ready_i(ordy), .spi_sclk_i(sclk), .spi_csb_n_i(csb), .spi_sdio_i(sdio),
        .spi_sdio_o(so), .spi_sdio_oe_o(soe), .pll_high_rate_o(pll),
        .driver_swing_o(swing), .bist_busy_o(busy));
    adcot_link_rx rx (.clk_i(clk), .arst_n_i(arst_n), .octet_i(oct), .octet_valid_i(ov),
        .octet_ready_o(ordy), .hold_i(hold), .slow_i(slow), .word_o(word), .word_valid_o(wv));
    always @(posedge clk)
        if (wv === 1'b1)
            got.push_back(word);
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Each serial clock level lasts four clocks, since the pins are sampled by the clock.
    task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 2'h0, a, d};
        csb = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sclk = 1'b0;
            drv = f[i];
            repeat (4) @(negedge clk);
            q = {q[6:0], sdio};
            sclk = 1'b1;
            repeat (4) @(negedge clk);
        end
        csb = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        spi(1'b0, a, d, dq);
    endtask
    task automatic put(input logic [13:0] s);
        smp = s;
        valid = 1'b1;
        for (int k = 0; k < 4000 && rdy !== 1'b1; k++)
            @(negedge clk);
        @(negedge clk);
        valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic getw(output logic [15:0] w);
        for (int k = 0; k < 4000 && got.size() == 0; k++)
            @(negedge clk);
        w = (got.size() > 0) ? got.pop_front() : 16'hxxxx;
    endtask
    task automatic expw(input string nm, input logic [13:0] e);
        logic [15:0] w;
        getw(w);
        chk(nm, {e, 2'h0}, w);
    endtask
    initial
    begin
        logic [7:0] q, h;
        logic [13:0] b, e;
        logic [15:0] w0, w1, w2, s1;
        int k;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk("rate reset", 16'h0001, {15'h0000, pll});
        spi(1'b1, OFS_FORMAT, 8'h00, q);
        chk("format reset", 16'h0001, {8'h00, q});
        wr(OFS_PLL_RATE, 8'h00);
        chk("rate low band", 16'h0000, {15'h0000, pll});
        wr(OFS_SWING, 8'h5a);
        chk("swing", 16'h005a, {8'h00, swing});
        spi(1'b1, 13'h0003, 8'h00, q);
        chk("unmapped read", 16'h0000, {8'h00, q});
        for (int f = 0; f < 4; f++)
        begin
            h = (f == 0) ? 8'h01 : (f == 1) ? 8'h00 : (f == 2) ? 8'h02 : 8'h05;
            slow = (f == 2);
            wr(OFS_FORMAT, h);
            foreach (ss[i])
                put(ss[i]);
            foreach (ss[i])
            begin
                b = ss[i] ^ 14'h2000;
                e = (h[1:0] == 2'h0) ? b : (h[1:0] == 2'h2) ? b ^ (b >> 1) : ss[i];
                expw("format word", h[2] ? ~e : e);
            end
        end
        slow = 1'b0;
        wr(OFS_USER_FIRST, 8'hfc);
        wr(13'h001a, 8'h12);
        wr(13'h001b, 8'h00);
        wr(13'h001c, 8'h2a);
        wr(OFS_FORMAT, 8'h01);
        for (int i = 0; i < 9; i++)
        begin
            wr(OFS_TEST_SEL, (i < 8) ? pc[i] : 8'h0f);
            repeat (3) put(14'h0555);
            getw(w0);
            getw(w1);
            getw(w2);
            e = (w0[15:2] === pa[i % 8]) ? pa[i % 8] : pb[i % 8];
            if (i < 8)
            begin
                chk("pattern word", {e, 2'h0}, w0);
                chk("pattern next", {(e === pa[i]) ? pb[i] : pa[i], 2'h0}, w1);
            end
            else
            begin
                chk("ramp step", 16'h0004, w1 - w0);
                chk("ramp next", 16'h0008, w2 - w0);
            end
        end
        wr(OFS_TEST_SEL, 8'h26);
        wr(OFS_TEST_SEL, 8'h06);
        repeat (3) put(14'h0555);
        expw("short pn first", 14'h125b);
        expw("short pn second", 14'h3c9a);
        expw("short pn third", 14'h2660);
        wr(OFS_FORMAT, 8'h00);
        wr(OFS_TEST_SEL, 8'h02);
        put(14'h0555);
        expw("full scale offset", 14'h3fff);
        wr(OFS_LINK_TEST, 8'h02);
        put(14'h0555);
        expw("link full scale", 14'h1fff);
        wr(OFS_LINK_TEST, 8'h00);
        wr(OFS_TEST_SEL, 8'h00);
        wr(OFS_FORMAT, 8'h01);
        hold = 1'b1;
        smp = 14'h0321;
        valid = 1'b1;
        for (k = 0; k < 20 && rdy === 1'b1; k++)
            @(negedge clk);
        valid = 1'b0;
        chk("fifo fill", 16'h0001, {15'h0000, k >= 8 && k <= 9});
        hold = 1'b0;
        slow = 1'b1;
        repeat (k) expw("fifo drain", 14'h0321);
        repeat (8) @(negedge clk);
        chk("fifo empty", 16'h0000, 16'(got.size()));
        slow = 1'b0;
        for (int r = 0; r < 3; r++)
        begin
            wr(OFS_BIST_CTL, (r < 2) ? 8'h05 : 8'h01);
            valid = 1'b1;
            k = 0;
            while (busy === 1'b1 && k < 600)
            begin
                k += int'(rdy === 1'b1);
                @(negedge clk);
            end
            valid = 1'b0;
            chk("self-test length", 16'h0200, 16'(k));
            repeat (40) @(negedge clk);
            chk("self-test on link", 16'h0200, 16'(got.size()));
            got.delete();
            spi(1'b1, OFS_SIG_LOW, 8'h00, q);
            spi(1'b1, OFS_SIG_HIGH, 8'h00, h);
            if (r == 0)
                s1 = {h, q};
            else if (r == 1)
                chk("signature repeat", s1, {h, q});
            else
                chk("signature resume", 16'h0001, {15'h0000, {h, q} != s1});
        end
        wr(OFS_SIG_LOW, ~q);
        spi(1'b1, OFS_SIG_LOW, 8'h00, h);
        chk("signature read only", {8'h00, q}, {8'h00, h});
        stop_test();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule

// [src/adcot_fifo.sv]
/*
 Synchronous word FIFO with valid and ready on both sides.
 Assumes one clock; depth must be a power of two of at least two.
*/
module adcot_fifo
    import adcot_pkg::*;
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_chk
        $error("FIFO depth must be a power of two of at least two.");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic ready_r;
    logic push;
    logic pop;

    // Ready is registered so that the block's ready pin comes straight from a flip-flop.
    assign in_ready_o = ready_r;
    assign count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);
    assign out_valid_o = count_r != '0;
    assign out_data_o = mem_r[rptr_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_r[wptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            count_r <= '0;
            ready_r <= 1'b1;
        end
        else
        begin
            wptr_r <= wptr_r + AW'(push);
            rptr_r <= rptr_r + AW'(pop);
            count_r <= count_nxt;
            ready_r <= count_nxt != (AW + 1)'(DEPTH);
        end
    end
endmodule

// [src/adcot_pkg.sv]
/*
 Shared constants and types for the converter output test block: register
 offsets, reset values, test pattern codes, generator seeds and carriers.
 Assumes a single encode clock domain and an 8-bit register file.
*/
package adcot_pkg;
    localparam int ADDR_W = 13;
    localparam int SMP_W = 14;
    localparam logic [12:0] OFS_TEST_SEL = 13'h000D;
    localparam logic [12:0] OFS_BIST_CTL = 13'h000E;
    localparam logic [12:0] OFS_FORMAT = 13'h0014;
    localparam logic [12:0] OFS_SWING = 13'h0015;
    localparam logic [12:0] OFS_USER_FIRST = 13'h0019;
    localparam logic [12:0] OFS_USER_LAST = 13'h0020;
    localparam logic [12:0] OFS_PLL_RATE = 13'h0021;
    localparam logic [12:0] OFS_SIG_LOW = 13'h0024;
    localparam logic [12:0] OFS_SIG_HIGH = 13'h0025;
    localparam logic [12:0] OFS_LINK_TEST = 13'h0062;
    localparam logic [7:0] RST_TEST_SEL = 8'h00;
    localparam logic [7:0] RST_BIST_CTL = 8'h00;
    localparam logic [7:0] RST_FORMAT = 8'h01;
    localparam logic [7:0] RST_SWING = 8'h00;
    localparam logic [7:0] RST_PLL_RATE = 8'h08;
    localparam logic [7:0] RST_LINK_TEST = 8'h00;
    localparam int FMT_INV_BIT = 2;
    localparam int PLL_RATE_BIT = 3;
    localparam int BIST_EN_BIT = 0;
    localparam int BIST_RESTART_BIT = 2;
    localparam int PN_LONG_RST_BIT = 4;
    localparam int PN_SHORT_RST_BIT = 5;
    localparam logic [1:0] FMT_OFFSET = 2'h0;
    localparam logic [1:0] FMT_TWOS = 2'h1;
    localparam logic [1:0] FMT_GRAY = 2'h2;
    localparam logic [3:0] TP_OFF = 4'h0;
    localparam logic [3:0] TP_MID = 4'h1;
    localparam logic [3:0] TP_POS_FS = 4'h2;
    localparam logic [3:0] TP_NEG_FS = 4'h3;
    localparam logic [3:0] TP_CHECKER = 4'h4;
    localparam logic [3:0] TP_PN_LONG = 4'h5;
    localparam logic [3:0] TP_PN_SHORT = 4'h6;
    localparam logic [3:0] TP_TOGGLE = 4'h7;
    localparam logic [3:0] TP_USER = 4'h8;
    localparam logic [3:0] TP_RAMP = 4'hF;
    localparam logic [13:0] WORD_MID = 14'h0000;
    localparam logic [13:0] WORD_POS_FS = 14'h1FFF;
    localparam logic [13:0] WORD_NEG_FS = 14'h2000;
    localparam logic [13:0] WORD_CHECK_1 = 14'h2AAA;
    localparam logic [13:0] WORD_CHECK_2 = 14'h1555;
    localparam logic [13:0] WORD_ONES = 14'h3FFF;
    localparam logic [22:0] SEED_SHORT = 23'h00_0092;
    localparam logic [22:0] SEED_LONG = 23'h00_3AFF;
    localparam int SHORT_LEN = 9;
    localparam int SHORT_TAP = 5;
    localparam int LONG_LEN = 23;
    localparam int LONG_TAP = 18;
    localparam logic [9:0] BIST_CYCLES = 10'h0200;
    localparam logic [1:0] TAIL_BITS = 2'h0;
    localparam logic [4:0] INSTR_BITS = 5'h10;
    localparam logic [4:0] FRAME_BITS = 5'h18;

    typedef struct packed {
        logic [13:0] word;
        logic [22:0] state;
    } adcot_prbs_s;
endpackage

// [src/adcot_top.sv]
/*
 Output formatting, test patterns and self-test of one converter channel,
 with the serial register port and the octet stream toward the link.
 Assumes all pins but the asynchronous reset are synchronous to the encode clock and sampled by it.
*/
module adcot_top
    import adcot_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [13:0] sample_bits_i,
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    output logic [7:0] octet_o,
    output logic octet_valid_o,
    input wire logic octet_ready_i,
    input wire logic spi_sclk_i,
    input wire logic spi_csb_n_i,
    input wire logic spi_sdio_i,
    output logic spi_sdio_o,
    output logic spi_sdio_oe_o,
    output logic pll_high_rate_o,
    output logic [7:0] driver_swing_o,
    output logic bist_busy_o
);
    typedef struct packed {
        logic [7:0] tsel;
        logic [7:0] bctl;
        logic [7:0] fmt;
        logic [7:0] swing;
        logic [7:0] pll;
        logic [7:0] ltst;
        logic [7:0][7:0] user;
        logic [15:0] sig;
        logic [22:0] bist_lfsr;
        logic [9:0] bist_cnt;
        logic [22:0] ps;
        logic [22:0] pl;
        logic phase;
        logic [13:0] ramp;
        logic sclk_q;
        logic [4:0] bitcnt;
        logic [15:0] ish;
        logic rd;
        logic [12:0] addr;
        logic [7:0] dsh;
        logic [7:0] osh;
        logic sdo;
        logic sdo_oe;
        logic [7:0] oct;
        logic ovld;
        logic half;
        logic [7:0] low;
    } adcot_state_s;

    adcot_state_s st_r;
    adcot_state_s st_nxt;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [13:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [13:0] fifo_out_data;

    // Advances a Fibonacci generator by fourteen bits, oldest bit in the MSB.
    // The bit shifted out is sent, so a fresh short generator starts with its seed bits and the long one with them inverted.
    function automatic adcot_prbs_s prbs14(input logic [22:0] s, input int len, input int tap,
                                           input logic inv);
        adcot_prbs_s r;
        logic fb;
        r.state = s;
        r.word = '0;
        for (int i = 0; i < SMP_W; i++)
        begin
            fb = r.state[len-1] ^ r.state[tap-1];
            r.word = {r.word[12:0], r.state[len-1] ^ inv};
            r.state = {r.state[21:0], fb};
            if (len < LONG_LEN)
            begin
                r.state[22:SHORT_LEN] = '0;
            end
        end
        return r;
    endfunction

    // Recodes a twos complement word into the selected output format.
    function automatic logic [13:0] recode(input logic [13:0] w, input logic [1:0] mode);
        logic [13:0] ob;
        ob = {~w[13], w[12:0]};
        case (mode)
            FMT_OFFSET: return ob;
            FMT_GRAY: return ob ^ (ob >> 1);
            default: return w;
        endcase
    endfunction

    // Pattern word for a test code; reports whether the format applies to it.
    function automatic logic [14:0] pattern(input logic [3:0] code, input logic ph,
                                            input logic [13:0] ramp, input logic [13:0] pnl,
                                            input logic [13:0] pns, input logic [63:0] usr);
        case (code)
            TP_MID: return {1'b1, WORD_MID};
            TP_POS_FS: return {1'b1, WORD_POS_FS};
            TP_NEG_FS: return {1'b1, WORD_NEG_FS};
            TP_CHECKER: return {1'b0, ph ? WORD_CHECK_2 : WORD_CHECK_1};
            TP_PN_LONG: return {1'b1, pnl};
            TP_PN_SHORT: return {1'b1, pns};
            TP_TOGGLE: return {1'b0, ph ? 14'h0000 : WORD_ONES};
            TP_USER: return {1'b1, ph ? {usr[31:24], usr[23:18]} : {usr[15:8], usr[7:2]}};
            TP_RAMP: return {1'b0, ramp};
            default: return {1'b1, WORD_MID};
        endcase
    endfunction

    // Register read mux; unmapped and open locations read as zero.
    function automatic logic [7:0] reg_read(input adcot_state_s s, input logic [12:0] a);
        if (a >= OFS_USER_FIRST && a <= OFS_USER_LAST)
        begin
            return s.user[3'(a - OFS_USER_FIRST)];
        end
        case (a)
            OFS_TEST_SEL: return s.tsel;
            OFS_BIST_CTL: return s.bctl;
            OFS_FORMAT: return s.fmt;
            OFS_SWING: return s.swing;
            OFS_PLL_RATE: return s.pll;
            OFS_SIG_LOW: return s.sig[7:0];
            OFS_SIG_HIGH: return s.sig[15:8];
            OFS_LINK_TEST: return s.ltst;
            default: return 8'h00;
        endcase
    endfunction

    always_comb
    begin
        adcot_prbs_s gl;
        adcot_prbs_s gs;
        adcot_prbs_s gb;
        logic [14:0] tp;
        logic [14:0] lp;
        logic [13:0] w;
        logic take;
        logic bist_on;
        logic rise;
        logic fall;
        logic [4:0] bc;
        st_nxt = st_r;
        gl = prbs14(st_r.pl, LONG_LEN, LONG_TAP, 1'b1);
        gs = prbs14(st_r.ps, SHORT_LEN, SHORT_TAP, 1'b0);
        gb = prbs14(st_r.bist_lfsr, SHORT_LEN, SHORT_TAP, 1'b0);
        bist_on = st_r.bctl[BIST_EN_BIT];
        take = sample_valid_i && fifo_in_ready;

        // Datapath: source, then format and inversion, then late link patterns.
        tp = pattern(st_r.tsel[3:0], st_r.phase, st_r.ramp,
                     st_r.tsel[PN_LONG_RST_BIT] ? SEED_LONG[13:0] : gl.word,
                     st_r.tsel[PN_SHORT_RST_BIT] ? SEED_SHORT[13:0] : gs.word,
                     st_r.user);
        if (bist_on)
        begin
            w = recode(gb.word, st_r.fmt[1:0]);
        end
        else if (st_r.tsel[3:0] != TP_OFF)
        begin
            w = tp[14] ? recode(tp[13:0], st_r.fmt[1:0]) : tp[13:0];
        end
        else
        begin
            w = recode(sample_bits_i, st_r.fmt[1:0]);
        end
        if (st_r.fmt[FMT_INV_BIT])
        begin
            w = ~w;
        end
        lp = pattern(st_r.ltst[3:0], st_r.phase, st_r.ramp, gl.word, gs.word, st_r.user);
        if (st_r.ltst[3:0] != TP_OFF)
        begin
            w = lp[13:0];
        end
        fifo_in_valid = sample_valid_i;
        fifo_in_data = w;

        if (take)
        begin
            st_nxt.phase = !st_r.phase;
            st_nxt.ramp = st_r.ramp + 14'h0001;
            st_nxt.pl = gl.state;
            st_nxt.ps = gs.state;
            if (bist_on)
            begin
                st_nxt.bist_lfsr = gb.state;
                st_nxt.sig = {st_r.sig[14:0], st_r.sig[15] ^ st_r.sig[12]} ^ {2'b00, w};
                st_nxt.bist_cnt = st_r.bist_cnt + 10'h001;
                if (st_r.bist_cnt == BIST_CYCLES - 10'h001)
                begin
                    st_nxt.bctl[BIST_EN_BIT] = 1'b0;
                end
            end
        end
        if (st_r.tsel[PN_LONG_RST_BIT])
        begin
            st_nxt.pl = SEED_LONG;
        end
        if (st_r.tsel[PN_SHORT_RST_BIT])
        begin
            st_nxt.ps = SEED_SHORT;
        end

        // Serial register port, sampled on the encode clock.
        st_nxt.sclk_q = spi_sclk_i;
        rise = spi_sclk_i && !st_r.sclk_q;
        fall = !spi_sclk_i && st_r.sclk_q;
        bc = st_r.bitcnt;
        if (spi_csb_n_i)
        begin
            st_nxt.bitcnt = '0;
            st_nxt.sdo_oe = 1'b0;
        end
        else if (rise)
        begin
            if (bc < INSTR_BITS)
            begin
                st_nxt.ish = {st_r.ish[14:0], spi_sdio_i};
                st_nxt.bitcnt = bc + 5'h01;
                if (bc == INSTR_BITS - 5'h01)
                begin
                    st_nxt.rd = st_r.ish[14];
                    st_nxt.addr = {st_r.ish[11:0], spi_sdio_i};
                    st_nxt.osh = reg_read(st_r, {st_r.ish[11:0], spi_sdio_i});
                end
            end
            else
            begin
                st_nxt.dsh = {st_r.dsh[6:0], spi_sdio_i};
                st_nxt.bitcnt = (bc == FRAME_BITS - 5'h01) ? INSTR_BITS : bc + 5'h01;
                if (bc == FRAME_BITS - 5'h01)
                begin
                    st_nxt.addr = st_r.addr - 13'h0001;
                    st_nxt.osh = reg_read(st_r, st_r.addr - 13'h0001);
                    if (!st_r.rd)
                    begin
                        case (st_r.addr)
                            OFS_TEST_SEL: st_nxt.tsel = {st_r.dsh[6:0], spi_sdio_i};
                            OFS_BIST_CTL:
                            begin
                                st_nxt.bctl = {st_r.dsh[6:0], spi_sdio_i};
                                st_nxt.bist_cnt = '0;
                                if (spi_sdio_i && st_r.dsh[BIST_RESTART_BIT - 1])
                                begin
                                    st_nxt.bist_lfsr = SEED_SHORT;
                                    st_nxt.sig = '0;
                                end
                            end
                            OFS_FORMAT: st_nxt.fmt = {st_r.dsh[6:0], spi_sdio_i};
                            OFS_SWING: st_nxt.swing = {st_r.dsh[6:0], spi_sdio_i};
                            OFS_PLL_RATE: st_nxt.pll = {st_r.dsh[6:0], spi_sdio_i};
                            OFS_LINK_TEST: st_nxt.ltst = {st_r.dsh[6:0], spi_sdio_i};
                            default:
                            begin
                                if (st_r.addr >= OFS_USER_FIRST && st_r.addr <= OFS_USER_LAST)
                                begin
                                    st_nxt.user[3'(st_r.addr - OFS_USER_FIRST)] =
                                        {st_r.dsh[6:0], spi_sdio_i};
                                end
                            end
                        endcase
                    end
                end
            end
        end
        else if (fall && bc >= INSTR_BITS && st_r.rd)
        begin
            st_nxt.sdo = st_r.osh[7];
            st_nxt.osh = {st_r.osh[6:0], 1'b0};
            st_nxt.sdo_oe = 1'b1;
        end

        // Octet serializer: high octet first, then low bits and tail.
        fifo_out_ready = 1'b0;
        if (!st_r.ovld || octet_ready_i)
        begin
            st_nxt.ovld = 1'b0;
            if (st_r.half)
            begin
                st_nxt.oct = st_r.low;
                st_nxt.ovld = 1'b1;
                st_nxt.half = 1'b0;
            end
            else if (fifo_out_valid)
            begin
                fifo_out_ready = 1'b1;
                st_nxt.oct = fifo_out_data[13:6];
                st_nxt.low = {fifo_out_data[5:0], TAIL_BITS};
                st_nxt.ovld = 1'b1;
                st_nxt.half = 1'b1;
            end
        end
    end

    // The whole state resets together so no generator starts mid-sequence.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_r <= '0;
            st_r.tsel <= RST_TEST_SEL;
            st_r.bctl <= RST_BIST_CTL;
            st_r.fmt <= RST_FORMAT;
            st_r.swing <= RST_SWING;
            st_r.pll <= RST_PLL_RATE;
            st_r.ltst <= RST_LINK_TEST;
            st_r.bist_lfsr <= SEED_SHORT;
            st_r.ps <= SEED_SHORT;
            st_r.pl <= SEED_LONG;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    adcot_fifo #(
        .WIDTH(SMP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    assign sample_ready_o = fifo_in_ready;
    assign octet_o = st_r.oct;
    assign octet_valid_o = st_r.ovld;
    assign spi_sdio_o = st_r.sdo;
    assign spi_sdio_oe_o = st_r.sdo_oe;
    assign pll_high_rate_o = st_r.pll[PLL_RATE_BIT];
    assign driver_swing_o = st_r.swing;
    assign bist_busy_o = st_r.bctl[BIST_EN_BIT];
endmodule
